// [ftpc_pkg.sv]
package ftpc_pkg;
   localparam int unsigned CNT_W_DEF = 8;
   localparam logic [11:0] OFS_SPEED_COUNT = 12'h000;
   localparam logic [11:0] OFS_PRELOAD = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_LIVE = 12'h00c;
   localparam logic [7:0] RST_SPEED_COUNT = 8'h00;
   localparam logic [7:0] RST_PRELOAD = 8'h00;
   localparam logic [1:0] SETTLE_PULSES = 2'h2;
   localparam logic [1:0] RST_SETTLE = 2'h0;
   localparam int unsigned STAT_VALID_BIT = 0;
   localparam int unsigned STAT_RUN_BIT = 1;
   localparam int unsigned STAT_SETTLE_LSB = 2;
   typedef enum logic {
      FTPC_WAIT = 1'b0,
      FTPC_RUN = 1'b1
   } ftpc_state_t;
endpackage

// [ftpc_cnt_if.sv]
`timescale 1ns/100ps
interface ftpc_cnt_if #(
   parameter int unsigned W = 8
);
   logic restart;
   logic [W-1:0] start_value;
   logic [W-1:0] result;
   logic [W-1:0] live;
   logic pulse_done;
   logic running;
   modport ctl (
      output restart,
      output start_value,
      input result,
      input live,
      input pulse_done,
      input running
   );
   modport cnt (
      input restart,
      input start_value,
      output result,
      output live,
      output pulse_done,
      output running
   );
endinterface

// [ftpc_counter.sv]
`timescale 1ns/100ps
module ftpc_counter #(
   parameter int unsigned W = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tach,
   ftpc_cnt_if.cnt bus
);
   localparam logic [W-1:0] CNT_MAX = '1;

   // holds at all ones so a stalled fan reads as slowest, not fast
   function automatic logic [W-1:0] sat_inc(input logic [W-1:0] v);
      sat_inc = (v == CNT_MAX) ? v : v + W'(1);
   endfunction

   ftpc_pkg::ftpc_state_t state;
   logic tach_prev;
   logic rise;
   logic [W-1:0] count;

   if (W < 1 || W > 32) begin : g_bad_width
      $error("ftpc_counter: width must be 1 to 32");
   end

   // a pulse is one tach period, rising edge to rising edge
   assign rise = tach & ~tach_prev;
   assign bus.live = count;
   assign bus.running = (state == ftpc_pkg::FTPC_RUN);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tach_prev <= 1'b0;
      end else begin
         tach_prev <= tach;
      end
   end

   // first edge after restart only arms; its period is partial
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= ftpc_pkg::FTPC_WAIT;
      end else if (bus.restart) begin
         state <= ftpc_pkg::FTPC_WAIT;
      end else if (rise) begin
         state <= ftpc_pkg::FTPC_RUN;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count <= W'(ftpc_pkg::RST_PRELOAD);
      end else if (bus.restart) begin
         count <= bus.start_value;
      end else if (rise) begin
         // the edge cycle is the first cycle of the new period
         count <= sat_inc(bus.start_value);
      end else if (state == ftpc_pkg::FTPC_RUN) begin
         count <= sat_inc(count);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus.result <= W'(ftpc_pkg::RST_SPEED_COUNT);
      end else if (!bus.restart && rise && state == ftpc_pkg::FTPC_RUN) begin
         bus.result <= count;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus.pulse_done <= 1'b0;
      end else begin
         bus.pulse_done <= !bus.restart && rise
            && state == ftpc_pkg::FTPC_RUN;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_count_step: assert property (
      state == ftpc_pkg::FTPC_RUN && !bus.restart && !rise
      && count != CNT_MAX |=> count == $past(count) + W'(1))
      else $error("count did not advance by one");

   a_latch_final: assert property (
      state == ftpc_pkg::FTPC_RUN && rise && !bus.restart
      |=> bus.result == $past(count) && bus.pulse_done)
      else $error("final count not latched at pulse end");

   a_result_hold: assert property (
      !(state == ftpc_pkg::FTPC_RUN && rise && !bus.restart)
      |=> $stable(bus.result))
      else $error("result changed outside a pulse end");

   a_count_saturate: assert property (
      state == ftpc_pkg::FTPC_RUN && count == CNT_MAX
      && !bus.restart && !rise |=> count == CNT_MAX)
      else $error("count wrapped instead of saturating");

   a_count_reload: assert property (
      rise && !bus.restart |=> count == sat_inc($past(bus.start_value)))
      else $error("count not reloaded at pulse edge");

   c_pulse_latched: cover property (bus.pulse_done);
   c_saturated: cover property (count == CNT_MAX ##1 rise);
endmodule

// [ftpc_top.sv]
`timescale 1ns/100ps
module ftpc_top #(
   parameter int unsigned CNT_W = ftpc_pkg::CNT_W_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic fan_channel_two,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   logic access;
   logic commit;
   logic addr_hit;
   logic wr_pre;
   logic [CNT_W-1:0] preload;
   logic [1:0] settle;
   logic [31:0] next_rdata;

   ftpc_cnt_if #(.W(CNT_W)) cnt_bus ();

   if (CNT_W < 1 || CNT_W > 8) begin : g_bad_width
      $error("ftpc_top: count width must be 1 to 8");
   end

   ftpc_counter #(.W(CNT_W)) u_counter (
      .clk(clk),
      .sys_rst(sys_rst),
      .tach(fan_channel_two),
      .bus(cnt_bus.cnt)
   );

   // one wait state: data is registered on the same edge that raises pready
   assign access = psel & penable;
   assign commit = access & pready;
   assign wr_pre = commit & pwrite & pstrb[0]
      & (paddr == ftpc_pkg::OFS_PRELOAD);

   // the written value goes straight to the counter in the same edge
   assign cnt_bus.restart = wr_pre;
   assign cnt_bus.start_value = wr_pre ? pwdata[CNT_W-1:0] : preload;

   always_comb begin
      addr_hit = 1'b1;
      next_rdata = 32'h00000000;
      unique case (paddr)
         ftpc_pkg::OFS_SPEED_COUNT: begin
            next_rdata[CNT_W-1:0] = cnt_bus.result;
         end
         ftpc_pkg::OFS_PRELOAD: begin
            next_rdata[CNT_W-1:0] = preload;
         end
         ftpc_pkg::OFS_STATUS: begin
            next_rdata[ftpc_pkg::STAT_VALID_BIT] =
               (settle == ftpc_pkg::SETTLE_PULSES);
            next_rdata[ftpc_pkg::STAT_RUN_BIT] = cnt_bus.running;
            next_rdata[ftpc_pkg::STAT_SETTLE_LSB +: 2] = settle;
         end
         ftpc_pkg::OFS_LIVE: begin
            next_rdata[CNT_W-1:0] = cnt_bus.live;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
      end else begin
         pready <= access & ~pready;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= access & ~pready & ~addr_hit;
      end
   end

   // reads of unmapped words return zero with an error
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
      end else if (access & ~pready) begin
         prdata <= next_rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         preload <= CNT_W'(ftpc_pkg::RST_PRELOAD);
      end else if (wr_pre) begin
         preload <= pwdata[CNT_W-1:0];
      end
   end

   // pulses seen since the last preload write, stops at two
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         settle <= ftpc_pkg::RST_SETTLE;
      end else if (wr_pre) begin
         settle <= ftpc_pkg::RST_SETTLE;
      end else if (cnt_bus.pulse_done
         && settle != ftpc_pkg::SETTLE_PULSES) begin
         settle <= settle + 2'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_result_read: assert property (
      commit && !pwrite && paddr == ftpc_pkg::OFS_SPEED_COUNT
      |-> prdata[CNT_W-1:0] == $past(cnt_bus.result)
      && (prdata >> CNT_W) == 32'h00000000)
      else $error("result read returned wrong data");

   a_preload_store: assert property (
      wr_pre |=> preload == $past(pwdata[CNT_W-1:0])
      ##1 preload == $past(pwdata[CNT_W-1:0], 2) || $past(wr_pre))
      else $error("preload not stored");

   a_restart_count: assert property (
      wr_pre |=> cnt_bus.live == $past(pwdata[CNT_W-1:0])
      && !cnt_bus.running && settle == ftpc_pkg::RST_SETTLE)
      else $error("preload write did not restart count");

   a_result_reset: assert property (
      @(posedge clk) disable iff (1'b0)
      sys_rst |=> cnt_bus.result == '0)
      else $error("result not cleared by reset");

   a_ready_pulse: assert property (
      access && !pready |=> pready ##1 !pready)
      else $error("pready not a single-cycle answer");

   c_preload_write: cover property (wr_pre);
   c_result_read: cover property (
      commit && !pwrite && paddr == ftpc_pkg::OFS_SPEED_COUNT);
   c_settled: cover property (settle == ftpc_pkg::SETTLE_PULSES);
   c_bad_addr: cover property (commit && pslverr);
endmodule

// [ftpc_tach_model.sv]
`timescale 1ns/100ps
module ftpc_tach_model (
   input wire logic clk,
   input wire logic en,
   input wire logic [9:0] per,
   output logic tach
);
   logic [9:0] cnt = 10'h000;
   // one-cycle high pulse every per cycles, idle low between runs
   always_ff @(posedge clk) begin
      if (!en || cnt == per - 10'h001) begin
         cnt <= 10'h000;
      end else begin
         cnt <= cnt + 10'h001;
      end
      tach <= en && (cnt == per - 10'h001);
   end
endmodule

// [fan_tach_pulse_counter_test.sv]
`timescale 1ns/100ps
module fan_tach_pulse_counter_test;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic en = 1'b0;
   logic [9:0] per = 10'h014;
   logic tach, pready, pslverr, e;
   logic [31:0] prdata, q, r0, r;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   ftpc_top u_ftpc_top (.clk(clk), .sys_rst(sys_rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .fan_channel_two(tach), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   ftpc_tach_model u_ftpc_tach_model (.clk(clk), .en(en), .per(per),
      .tach(tach));
   always #25 clk = ~clk;
   task automatic results();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // cuts a hang short; tests need under 1500 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end
   task automatic check(string nm, logic [31:0] s, logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         failures++;
         $display("mismatch %s exp %h seen %h", nm, x, s);
      end
   endtask
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pulses(int n);
      repeat (n) begin
         @(posedge clk);
         while (tach !== 1'b1) @(posedge clk);
      end
   endtask
   // first latch after a preload write is discarded by waiting 3 edges
   task automatic meas(logic [7:0] pre, logic [9:0] p);
      apb(1'b1, 12'h004, {24'h0, pre});
      per <= p;
      en <= 1'b1;
      pulses(3);
      en <= 1'b0;
      repeat (4) @(posedge clk);
      apb(1'b0, 12'h000, 32'h0);
      r = q;
   endtask
   task automatic t_regs();
      apb(1'b0, 12'h000, 32'h0);
      check("result rst", q, 32'h0);
      check("mapped err", {31'h0, e}, 32'h0);
      apb(1'b1, 12'h000, 32'h5a);
      apb(1'b0, 12'h000, 32'h0);
      check("result ro", q, 32'h0);
      apb(1'b1, 12'h004, 32'hffffffa5);
      apb(1'b0, 12'h004, 32'h0);
      check("preload", q, 32'ha5);
      pstrb <= 4'h0;
      apb(1'b1, 12'h004, 32'h3c);
      pstrb <= 4'hf;
      apb(1'b0, 12'h004, 32'h0);
      check("strobe off", q, 32'ha5);
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped err", {31'h0, e}, 32'h1);
      check("unmapped data", q, 32'h0);
      $display("done regs");
   endtask
   task automatic t_count();
      meas(8'h00, 10'd20);
      r0 = r;
      check("period abs", r0, 32'h14);
      meas(8'h00, 10'd30);
      check("period", r, r0 + 32'd10);
      repeat (50) @(posedge clk);
      apb(1'b0, 12'h000, 32'h0);
      check("hold", q, r);
      meas(8'h05, 10'd20);
      check("start value", r, r0 + 32'd5);
      $display("done count");
   endtask
   task automatic t_sat();
      meas(8'h40, 10'd300);
      check("saturate", r, 32'hff);
      apb(1'b0, 12'h008, 32'h0);
      check("status settled", q, 32'hb);
      $display("done sat");
   endtask
   // restart disarms, so one edge after a write latches nothing
   task automatic t_restart();
      apb(1'b1, 12'h004, 32'h0);
      en <= 1'b1;
      per <= 10'd20;
      pulses(1);
      en <= 1'b0;
      repeat (4) @(posedge clk);
      apb(1'b0, 12'h000, 32'h0);
      check("restart", q, 32'hff);
      apb(1'b0, 12'h008, 32'h0);
      check("status armed", q, 32'h2);
      apb(1'b1, 12'h004, 32'h33);
      apb(1'b0, 12'h00c, 32'h0);
      check("live restart", q, 32'h33);
      apb(1'b0, 12'h008, 32'h0);
      check("status restart", q, 32'h0);
      $display("done restart");
   endtask
   // second reset with the fan stopped and the counter disarmed; result held 0xff before it
   task automatic t_reset();
      sys_rst <= 1'b1;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, 12'h000, 32'h0);
      check("result rerst", q, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      check("preload rerst", q, 32'h0);
      $display("done reset");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_count();
      t_sat();
      t_restart();
      t_reset();
      results();
   end
endmodule
